// ---- design/iop_port.sv ----
// isa i/o register port: decode, index/data pairs, 16-bit select and interrupt
//
// Contract
// - read strobe low on hit: drive register
// - write latched at write strobe rising edge
// - wide index write: index low, data high
// - 16-bit select only for listed ports
// - three-state interrupt output governed by crt register
// - address enable high: no cycle starts, a pending write is dropped
// - select decoded from address, colour select and enable
// - reset floats outputs, clears all registers
`timescale 1ns/1ps
module iop_port #(
  parameter int IDX_W = 5 // index bits kept per group; higher index bits alias
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // isa strobes and address
  input wire logic IORD_N,
  input wire logic IOWR_N,
  input wire logic AEN,
  input wire logic SBHE_N,
  input wire logic [15:0] SA,
  // isa data bus, three signals
  input wire logic [15:0] SD_I,
  output logic [15:0] SD_O,
  output logic SD_OE,
  // open-collector 16-bit i/o select
  output logic IOCS16_N_O,
  output logic IOCS16_N_OE,
  // three-state interrupt request
  output logic IRQ_O,
  output logic IRQ_OE,
  // configuration and display event inputs
  input wire logic COLOR_SEL,
  input wire logic VRETRACE
);
  localparam int MEM_AW = 2 + IDX_W;

  // whole state of the port
  typedef struct packed {
    iop_pkg::iop_pins_type s1; // first sync stage, read only by s2
    iop_pkg::iop_pins_type s2; // second sync stage
    logic rd_n_p; // s2 delayed, for edge detection
    logic wr_n_p;
    logic vr_p;
    iop_pkg::iop_fsm_type fsm;
    iop_pkg::iop_port_type port; // port hit by the current cycle
    logic wide; // byte-high enable seen with the strobe
    logic [15:0] wdata; // last data sampled while write strobe low
    logic [7:0] idx_seq;
    logic [7:0] idx_gfx;
    logic [7:0] idx_crt;
    logic [7:0] int_ctrl; // mirror of the crt interrupt control register
    logic pending; // interrupt pending flag
    logic [15:0] sd_o;
    logic sd_oe;
    logic cs16_oe;
    logic irq_o;
    logic irq_oe;
  } iop_state_type;

  iop_state_type q; // registered state
  iop_state_type d; // next state
  iop_pkg::iop_pins_type pins; // raw pin group
  iop_pkg::iop_port_type hit; // decode of synced address
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [MEM_AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  logic vr_rise;
  logic int_clear;
  logic [7:0] is1_val;

  // gather the asynchronous pins
  assign pins = '{rd_n: IORD_N, wr_n: IOWR_N, aen: AEN, sbhe_n: SBHE_N, color: COLOR_SEL,
                  vretrace: VRETRACE, sa: SA, sd: SD_I};

  // group and index to store address
  function automatic logic [MEM_AW-1:0] store_addr(input logic [1:0] grp,
                                                   input logic [7:0] idx);
    return {grp, idx[IDX_W-1:0]};
  endfunction : store_addr

  // group of a port
  function automatic logic [1:0] port_grp(input iop_pkg::iop_port_type p);
    logic [1:0] g;
    g = iop_pkg::GRP_CRT;
    if (p == iop_pkg::PORT_SEQ_IDX || p == iop_pkg::PORT_SEQ_DAT) g = iop_pkg::GRP_SEQ;
    else if (p == iop_pkg::PORT_GFX_IDX || p == iop_pkg::PORT_GFX_DAT) g = iop_pkg::GRP_GFX;
    return g;
  endfunction : port_grp

  // indexed register store
  iop_regstore #(.ADDR_W(MEM_AW)) u_store (
    .clk(CLK),
    .rst(SYS_RST),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // next state: sync, decode, bus sequencing, interrupt
  always_comb begin
    d = q;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = 8'h00;
    mem_raddr = '0;
    int_clear = 1'b0;
    // two stage synchroniser on every pin
    d.s1 = pins;
    d.s2 = q.s1;
    d.rd_n_p = q.s2.rd_n;
    d.wr_n_p = q.s2.wr_n;
    d.vr_p = q.s2.vretrace;
    hit = iop_pkg::iop_decode(q.s2.sa, q.s2.color);
    rd_fall = q.rd_n_p && !q.s2.rd_n;
    wr_fall = q.wr_n_p && !q.s2.wr_n;
    wr_rise = !q.wr_n_p && q.s2.wr_n;
    vr_rise = q.s2.vretrace && !q.vr_p;
    // select held while the synced address hits and no dma cycle runs
    d.cs16_oe = !q.s2.aen && (hit != iop_pkg::PORT_NONE);
    // status one shows the pending flag, other bits read zero
    is1_val = 8'h00;
    is1_val[iop_pkg::IS1_PENDING_BIT] = q.pending;
    case (q.fsm)
      iop_pkg::ST_IDLE: begin
        // dma cycles are never taken
        if (!q.s2.aen && hit != iop_pkg::PORT_NONE) begin
          if (rd_fall) begin
            d.port = hit;
            d.fsm = iop_pkg::ST_RD_FETCH;
            // fetch the indexed register for either port of a pair
            case (hit)
              iop_pkg::PORT_SEQ_IDX, iop_pkg::PORT_SEQ_DAT: begin
                mem_raddr = store_addr(iop_pkg::GRP_SEQ, q.idx_seq);
              end
              iop_pkg::PORT_GFX_IDX, iop_pkg::PORT_GFX_DAT: begin
                mem_raddr = store_addr(iop_pkg::GRP_GFX, q.idx_gfx);
              end
              default: begin
                mem_raddr = store_addr(iop_pkg::GRP_CRT, q.idx_crt);
              end
            endcase
          end else if (wr_fall) begin
            d.port = hit;
            d.wide = !q.s2.sbhe_n;
            d.wdata = q.s2.sd;
            d.fsm = iop_pkg::ST_WR_CAPTURE;
          end
        end
      end
      iop_pkg::ST_RD_FETCH: begin
        // index port: index low, data high; data port: byte on both lanes
        d.sd_oe = 1'b1;
        d.fsm = iop_pkg::ST_RD_DRIVE;
        case (q.port)
          iop_pkg::PORT_SEQ_IDX: d.sd_o = {mem_rdata, q.idx_seq};
          iop_pkg::PORT_GFX_IDX: d.sd_o = {mem_rdata, q.idx_gfx};
          iop_pkg::PORT_CRT_IDX: d.sd_o = {mem_rdata, q.idx_crt};
          iop_pkg::PORT_IS1: d.sd_o = {is1_val, is1_val};
          default: d.sd_o = {mem_rdata, mem_rdata};
        endcase
      end
      iop_pkg::ST_RD_DRIVE: begin
        // hold data until the host lifts the read strobe
        if (q.s2.rd_n) begin
          d.sd_oe = 1'b0;
          d.fsm = iop_pkg::ST_IDLE;
        end
      end
      iop_pkg::ST_WR_CAPTURE: begin
        if (q.s2.aen) begin
          d.fsm = iop_pkg::ST_IDLE; // dma took the bus: drop the write
        end else if (wr_rise) begin
          // commit on the strobe's rising edge with data sampled while low
          d.fsm = iop_pkg::ST_IDLE;
          case (q.port)
            iop_pkg::PORT_SEQ_IDX, iop_pkg::PORT_GFX_IDX, iop_pkg::PORT_CRT_IDX: begin
              if (q.port == iop_pkg::PORT_SEQ_IDX) d.idx_seq = q.wdata[7:0];
              else if (q.port == iop_pkg::PORT_GFX_IDX) d.idx_gfx = q.wdata[7:0];
              else d.idx_crt = q.wdata[7:0];
              // wide write: new index first, then high byte into it
              if (q.wide) begin
                mem_we = 1'b1;
                mem_waddr = store_addr(port_grp(q.port), q.wdata[7:0]);
                mem_wdata = q.wdata[15:8];
              end
            end
            iop_pkg::PORT_SEQ_DAT, iop_pkg::PORT_GFX_DAT, iop_pkg::PORT_CRT_DAT: begin
              // odd port: high lane when byte-high enable, else low lane
              mem_we = 1'b1;
              mem_wdata = q.wide ? q.wdata[15:8] : q.wdata[7:0];
              if (q.port == iop_pkg::PORT_SEQ_DAT) begin
                mem_waddr = store_addr(iop_pkg::GRP_SEQ, q.idx_seq);
              end else if (q.port == iop_pkg::PORT_GFX_DAT) begin
                mem_waddr = store_addr(iop_pkg::GRP_GFX, q.idx_gfx);
              end else begin
                mem_waddr = store_addr(iop_pkg::GRP_CRT, q.idx_crt);
              end
            end
            default: begin
              // status one is read only
            end
          endcase
          // keep a live copy of the interrupt control register
          if (mem_we && mem_waddr == store_addr(iop_pkg::GRP_CRT,
                                                 iop_pkg::CRT_INT_CTRL_INDEX)) begin
            d.int_ctrl = mem_wdata;
            int_clear = !mem_wdata[iop_pkg::INT_CLEAR_N_BIT];
          end
        end else begin
          d.wdata = q.s2.sd;
          d.wide = !q.s2.sbhe_n;
        end
      end
      default: begin
        d.fsm = iop_pkg::ST_IDLE;
      end
    endcase
    // pending: a retrace edge in the clearing cycle still sets the flag
    d.pending = (q.pending && !int_clear)
                || (vr_rise && q.int_ctrl[iop_pkg::INT_CLEAR_N_BIT]);
    d.irq_oe = !q.int_ctrl[iop_pkg::INT_DISABLE_BIT];
    d.irq_o = q.pending && !q.int_ctrl[iop_pkg::INT_DISABLE_BIT];
  end

  // state register; reset clears everything and floats all outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register, except the select level, which is tied low
  assign SD_O = q.sd_o;
  assign SD_OE = q.sd_oe;
  assign IOCS16_N_O = 1'b0; // open collector only ever pulls low
  assign IOCS16_N_OE = q.cs16_oe;
  assign IRQ_O = q.irq_o;
  assign IRQ_OE = q.irq_oe;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_read_drive_time: assert property (
    (q.fsm == iop_pkg::ST_IDLE && rd_fall && !q.s2.aen && hit != iop_pkg::PORT_NONE)
    |-> ##2 SD_OE) else $error("read hit not driven two cycles later");
  a_read_release: assert property (
    (SD_OE && q.fsm == iop_pkg::ST_RD_DRIVE && q.s2.rd_n) |=> !SD_OE)
    else $error("data bus held after read strobe rose");
  a_write_index: assert property (
    (q.fsm == iop_pkg::ST_WR_CAPTURE && wr_rise && !q.s2.aen
     && q.port == iop_pkg::PORT_SEQ_IDX) |=> q.idx_seq == $past(q.wdata[7:0]))
    else $error("index not latched at write strobe rise");
  a_wide_write: assert property (
    (q.fsm == iop_pkg::ST_WR_CAPTURE && wr_rise && !q.s2.aen && q.wide
     && q.port == iop_pkg::PORT_CRT_IDX)
    |-> mem_we && mem_wdata == q.wdata[15:8]
        && mem_waddr == store_addr(iop_pkg::GRP_CRT, q.wdata[7:0]))
    else $error("wide index write did not store high byte");
  a_select_hit: assert property (
    (!q.s2.aen && q.s2.sa == iop_pkg::GFX_DATA_ADDR) |=> IOCS16_N_OE)
    else $error("16-bit select missing for decoded port");
  a_select_miss: assert property (
    (hit == iop_pkg::PORT_NONE) |=> !IOCS16_N_OE)
    else $error("16-bit select on undecoded address");
  a_dma_ignore: assert property (
    (q.s2.aen && q.fsm == iop_pkg::ST_IDLE) |=> q.fsm == iop_pkg::ST_IDLE && !IOCS16_N_OE)
    else $error("i/o cycle taken during dma");
  a_irq_disable: assert property (
    q.int_ctrl[iop_pkg::INT_DISABLE_BIT] |=> !IRQ_OE && !IRQ_O)
    else $error("interrupt driven while disabled");
  a_reset_float: assert property (@(posedge CLK) disable iff (1'b0)
    SYS_RST |=> !SD_OE && !IOCS16_N_OE && !IRQ_OE && q.fsm == iop_pkg::ST_IDLE)
    else $error("outputs not floated by reset");
  a_mono_color: assert property (
    (!q.s2.color && q.s2.sa == iop_pkg::CRT_INDEX_COLOR) |=> !IOCS16_N_OE)
    else $error("colour crt port decoded in mono mode");
endmodule : iop_port

// ---- design/iop_regstore.sv ----
// indexed register store for the three register groups, registered read port
`timescale 1ns/1ps
module iop_regstore #(
  parameter int ADDR_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [ADDR_W-1:0] raddr,
  output logic [7:0] rdata
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0] mem_q [DEPTH]; // one byte per indexed register

  // per entry flop with reset, so a reset really clears every register
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (rst) begin
        mem_q[i] <= 8'h00;
      end else if (we && (waddr == ADDR_W'(i))) begin
        mem_q[i] <= wdata;
      end
    end
  end

  // read data leaves from a register, one cycle after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule : iop_regstore

// ---- include/iop_pkg.sv ----
// constants, types and address decode shared by the isa i/o register port
package iop_pkg;
  // decoded i/o port addresses
  localparam logic [15:0] SEQ_INDEX_ADDR = 16'h03C4;
  localparam logic [15:0] SEQ_DATA_ADDR = 16'h03C5;
  localparam logic [15:0] GFX_INDEX_ADDR = 16'h03CE;
  localparam logic [15:0] GFX_DATA_ADDR = 16'h03CF;
  localparam logic [15:0] CRT_INDEX_MONO = 16'h03B4;
  localparam logic [15:0] CRT_DATA_MONO = 16'h03B5;
  localparam logic [15:0] CRT_INDEX_COLOR = 16'h03D4;
  localparam logic [15:0] CRT_DATA_COLOR = 16'h03D5;
  localparam logic [15:0] IS1_MONO = 16'h03BA;
  localparam logic [15:0] IS1_COLOR = 16'h03DA;
  // register groups inside the indexed store
  localparam logic [1:0] GRP_SEQ = 2'h0;
  localparam logic [1:0] GRP_GFX = 2'h1;
  localparam logic [1:0] GRP_CRT = 2'h2;
  // crt interrupt control register: index and fields
  localparam logic [7:0] CRT_INT_CTRL_INDEX = 8'h11;
  localparam logic [7:0] CRT_INT_CTRL_RESET = 8'h00;
  localparam int INT_CLEAR_N_BIT = 4;
  localparam int INT_DISABLE_BIT = 5;
  // input status one: pending interrupt flag position
  localparam int IS1_PENDING_BIT = 7;
  // reset values of the index ports
  localparam logic [7:0] INDEX_RESET = 8'h00;

  // which decoded port an address hits
  typedef enum logic [2:0] {
    PORT_NONE, PORT_SEQ_IDX, PORT_SEQ_DAT, PORT_GFX_IDX, PORT_GFX_DAT,
    PORT_CRT_IDX, PORT_CRT_DAT, PORT_IS1
  } iop_port_type;

  // bus cycle sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RD_FETCH, ST_RD_DRIVE, ST_WR_CAPTURE} iop_fsm_type;

  // asynchronous pin group, carried through the synchroniser as one word
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic aen;
    logic sbhe_n;
    logic color;
    logic vretrace;
    logic [15:0] sa;
    logic [15:0] sd;
  } iop_pins_type;

  // address decode: crt and status ports follow the mono/colour select
  function automatic iop_port_type iop_decode(input logic [15:0] a, input logic color);
    iop_port_type p;
    p = PORT_NONE;
    if (a == SEQ_INDEX_ADDR) p = PORT_SEQ_IDX;
    else if (a == SEQ_DATA_ADDR) p = PORT_SEQ_DAT;
    else if (a == GFX_INDEX_ADDR) p = PORT_GFX_IDX;
    else if (a == GFX_DATA_ADDR) p = PORT_GFX_DAT;
    else if (a == (color ? CRT_INDEX_COLOR : CRT_INDEX_MONO)) p = PORT_CRT_IDX;
    else if (a == (color ? CRT_DATA_COLOR : CRT_DATA_MONO)) p = PORT_CRT_DAT;
    else if (a == (color ? IS1_COLOR : IS1_MONO)) p = PORT_IS1;
    return p;
  endfunction : iop_decode
endpackage : iop_pkg

// ---- verif/iop_host_model.sv ----
// isa host bus controller model: i/o strobes, address, byte enable and data wire
`timescale 1ns/1ps
module iop_host_model (
  // clock
  input wire logic clk,
  // device side of the data bus
  input wire logic [15:0] sd_o,
  input wire logic sd_oe,
  // host strobes, address and resolved data
  output logic iord_n,
  output logic iowr_n,
  output logic aen,
  output logic sbhe_n,
  output logic [15:0] sa,
  output logic [15:0] sd_i
);
  logic [15:0] hdata; // host lane value, inverted on release so stale data never matches
  // resolved wire: the device wins while it drives
  assign sd_i = sd_oe ? sd_o : hdata;
  // idle bus at time zero
  initial begin
    iord_n = 1'b1;
    iowr_n = 1'b1;
    aen = 1'b0;
    sbhe_n = 1'b1;
    sa = 16'h0000;
    hdata = 16'h0000;
  end
  // address only, no strobe, long enough for the registered select to follow
  task automatic set_addr(input logic [15:0] addr, input logic dma);
    @(posedge clk);
    #1;
    sa = addr;
    aen = dma;
    repeat (6) @(posedge clk);
    // hand back off the edge, so follow-up stimulus never races the sampling edge
    #1;
  endtask : set_addr
  // one i/o cycle: address first, strobe low eight cycles, data held past the rise
  task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [15:0] data,
      input logic wide, input logic dma, output logic [15:0] rdata);
    @(posedge clk);
    #1;
    sa = addr;
    aen = dma;
    sbhe_n = ~wide;
    if (wr) hdata = data;
    @(posedge clk);
    #1;
    if (wr) iowr_n = 1'b0;
    else iord_n = 1'b0;
    repeat (8) @(posedge clk);
    rdata = sd_i;
    #1;
    iord_n = 1'b1;
    iowr_n = 1'b1;
    // data must outlive the synchronised strobe rise
    repeat (4) @(posedge clk);
    #1;
    hdata = ~hdata;
    aen = 1'b0;
    sbhe_n = 1'b1;
    repeat (4) @(posedge clk);
    // hand back off the edge, so follow-up stimulus never races the sampling edge
    #1;
  endtask : io_cycle
endmodule : iop_host_model

// ---- verif/iop_port_test.sv ----
// self-checking testbench for the isa i/o register port
`timescale 1ns/1ps
module iop_port_test;
  logic clk = 1'b0; // 250 mhz core clock
  logic sys_rst = 1'b1;
  logic color_sel = 1'b1;
  logic vretrace = 1'b0;
  logic iord_n, iowr_n, aen, sbhe_n, sd_oe, cs_o, cs_oe, irq_o, irq_oe;
  logic [15:0] sa, sd_i, sd_o, rd;
  int err_count = 0;
  int checks = 0;
  // port tables for the three groups, colour set
  localparam logic [15:0] IDX_A [3] = '{iop_pkg::SEQ_INDEX_ADDR, iop_pkg::GFX_INDEX_ADDR,
      iop_pkg::CRT_INDEX_COLOR};
  localparam logic [15:0] DAT_A [3] = '{iop_pkg::SEQ_DATA_ADDR, iop_pkg::GFX_DATA_ADDR,
      iop_pkg::CRT_DATA_COLOR};
  // select table: listed ports, then two neighbours that must stay silent
  localparam logic [15:0] SEL_A [12] = '{16'h03C4, 16'h03C5, 16'h03CE, 16'h03CF, 16'h03B4,
      16'h03B5, 16'h03BA, 16'h03D4, 16'h03D5, 16'h03DA, 16'h03C6, 16'h03B0};
  localparam logic [11:0] MONO_HIT = 12'h07F;
  localparam logic [11:0] COL_HIT = 12'h38F;
  always #2 clk = ~clk;
  iop_port u_iop_port (.CLK(clk), .SYS_RST(sys_rst), .IORD_N(iord_n), .IOWR_N(iowr_n),
    .AEN(aen), .SBHE_N(sbhe_n), .SA(sa), .SD_I(sd_i), .SD_O(sd_o), .SD_OE(sd_oe),
    .IOCS16_N_O(cs_o), .IOCS16_N_OE(cs_oe), .IRQ_O(irq_o), .IRQ_OE(irq_oe),
    .COLOR_SEL(color_sel), .VRETRACE(vretrace));
  iop_host_model u_iop_host_model (.clk(clk), .sd_o(sd_o), .sd_oe(sd_oe), .iord_n(iord_n),
    .iowr_n(iowr_n), .aen(aen), .sbhe_n(sbhe_n), .sa(sa), .sd_i(sd_i));
  // compare a bus word
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16
  // compare a pin flag
  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  // write helper, optional dma cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w, input logic m);
    u_iop_host_model.io_cycle(1'b1, a, d, w, m, rd);
  endtask : wr
  // read and compare
  task automatic rdchk(input string what, input logic [15:0] a, input logic [15:0] exp);
    u_iop_host_model.io_cycle(1'b0, a, 16'h0000, 1'b0, 1'b0, rd);
    chk16(what, exp, rd);
    // bus must be released well after the read strobe went back high
    chk1("sd_oe after read", 1'b0, sd_oe);
  endtask : rdchk
  // reset floats every output, then index reads zero
  task automatic t_reset();
    repeat (15) @(posedge clk);
    #1;
    chk1("sd_oe in reset", 1'b0, sd_oe);
    chk1("cs16 in reset", 1'b0, cs_oe);
    chk1("irq_oe in reset", 1'b0, irq_oe);
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (6) @(posedge clk);
    chk1("irq_oe after reset", 1'b1, irq_oe);
    rdchk("seq index reset", iop_pkg::SEQ_INDEX_ADDR, 16'h0000);
  endtask : t_reset
  // byte writes through index and data ports of every group
  task automatic t_groups();
    logic [7:0] v;
    for (int g = 0; g < 3; g++) begin
      v = 8'h50 + 8'(g);
      wr(IDX_A[g], 16'h0003, 1'b0, 1'b0);
      wr(DAT_A[g], {8'h00, v}, 1'b0, 1'b0);
      rdchk("group data", DAT_A[g], {v, v});
      rdchk("group index", IDX_A[g], {v, 8'h03});
    end
  endtask : t_groups
  // wide index write, then a dma write that must be ignored
  task automatic t_wide_dma();
    wr(iop_pkg::GFX_INDEX_ADDR, 16'hC307, 1'b1, 1'b0);
    rdchk("wide data", iop_pkg::GFX_DATA_ADDR, 16'hC3C3);
    wr(iop_pkg::GFX_INDEX_ADDR, 16'hFF1F, 1'b1, 1'b1);
    rdchk("dma ignored", iop_pkg::GFX_INDEX_ADDR, 16'hC307);
    // wide write to a data port takes the high lane
    wr(iop_pkg::GFX_DATA_ADDR, 16'h5A00, 1'b1, 1'b0);
    rdchk("wide data port", iop_pkg::GFX_DATA_ADDR, 16'h5A5A);
    u_iop_host_model.set_addr(iop_pkg::SEQ_INDEX_ADDR, 1'b1);
    chk1("cs16 under dma", 1'b0, cs_oe);
  endtask : t_wide_dma
  // select decode in both address sets
  task automatic t_select();
    for (int c = 0; c < 2; c++) begin
      color_sel = c[0];
      for (int i = 0; i < 12; i++) begin
        u_iop_host_model.set_addr(SEL_A[i], 1'b0);
        chk1("cs16 decode", c[0] ? COL_HIT[i] : MONO_HIT[i], cs_oe);
        chk1("cs16 pin level", 1'b0, cs_o);
      end
    end
  endtask : t_select
  // mono crt ports reach the same store as the colour ones
  task automatic t_mono();
    color_sel = 1'b0;
    wr(iop_pkg::CRT_INDEX_MONO, 16'hA509, 1'b1, 1'b0);
    rdchk("mono crt data", iop_pkg::CRT_DATA_MONO, 16'hA5A5);
    rdchk("mono status", iop_pkg::IS1_MONO, 16'h0000);
    color_sel = 1'b1;
    rdchk("colour crt index", iop_pkg::CRT_INDEX_COLOR, 16'hA509);
  endtask : t_mono
  // retrace pulse: four cycles high, then eight cycles low
  task automatic pulse();
    @(posedge clk);
    #1;
    vretrace = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    vretrace = 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse
  // interrupt set, masked, cleared and re-enabled
  task automatic t_irq();
    wr(iop_pkg::CRT_INDEX_COLOR, 16'h1011, 1'b1, 1'b0);
    pulse();
    chk1("irq raised", 1'b1, irq_o);
    rdchk("status pending", iop_pkg::IS1_COLOR, 16'h8080);
    wr(iop_pkg::CRT_INDEX_COLOR, 16'h3011, 1'b1, 1'b0);
    chk1("irq masked", 1'b0, irq_o);
    chk1("irq floated", 1'b0, irq_oe);
    wr(iop_pkg::IS1_COLOR, 16'h0000, 1'b0, 1'b0);
    rdchk("status read only", iop_pkg::IS1_COLOR, 16'h8080);
    wr(iop_pkg::CRT_INDEX_COLOR, 16'h0011, 1'b1, 1'b0);
    pulse();
    rdchk("status cleared", iop_pkg::IS1_COLOR, 16'h0000);
    chk1("irq driven again", 1'b1, irq_oe);
    chk1("irq idle", 1'b0, irq_o);
  endtask : t_irq
  // verdict and end of run
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    t_reset();
    t_groups();
    t_wide_dma();
    t_select();
    t_mono();
    t_irq();
    tally_and_finish();
  end
endmodule : iop_port_test
